/* File: evfilt.sv */
// evfilt.sv: front-end retired and off-core response event qualifiers.
// assumes: one core clock; miss sources flag first miss per line/page;
// the general event select (c6h / 01h) is set by software elsewhere.
//
// Operation
// - low 8 bits of front-end qualifier select the counted sub-event
// - bits 19:8 give the minimum consecutive cycles of a read gap
// - bits 22:20 give the minimum empty slots per cycle
// - gap counted once a run reaches the cycle count with enough slots
// - empty slot: one of 4 unfilled slots in a cycle without stall
// - only first miss to a line or page counts as a true miss
// - only instructions retiring on the architectural path are counted
// - no second count on the last counted line; alternating lines each count again
// - an instruction straddling two lines is counted once
// - a multi-cycle allocation instruction counts its gaps once
// - a fused pair with misses yields a single count
// - misses outside a boundary go to the next retiring instruction
// - off-core filter: request 15:0, supplier 29:16, snoop 37:31
// - request bit 0 selects demand data reads
// - request bit 1 selects demand ownership reads
// - request bit 2 selects demand fetches and first-level prefetch
// - request bit 15 selects miscellaneous; bits 14:3 reserved
// - supplier bit 16 matches any response
// - bits 17..20 match no supplier and l3 modified/exclusive/shared
// - bit 22 fourth-level hit, 30 super line, 26 local memory
// - snoop bit 31 no details, bit 32 no snoop needed
// - bit 33 snoop missed all, bit 34 hit without forwarding
// - bit 35 forwarded from remote, bit 36 modified hit
// - bit 37 non-memory target address
`timescale 1ns/1ns
`default_nettype none
`include "evfilt_consts.svh"

module evfilt (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire evfilt_pkg::reg_wr_s WR_I,
   input wire logic [2:0] FILLED_SLOTS_I,
   input wire logic BACK_STALL_I,
   input wire evfilt_pkg::retire_s RETIRE_I,
   input wire evfilt_pkg::ocr_rsp_s OCR_RSP_I,
   output logic [63:0] FE_QUAL_O,
   output logic [63:0] OCR_FILT_O,
   output logic FE_EVENT_O,
   output logic OCR_MATCH_O
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // does a retired miss kind match the selected sub-event
   function automatic logic sub_match(input logic [7:0] sel,
                                      input logic [7:0] kind);
      logic m;
      m = 1'b0;
      if (sel == `SUB_ANY_DECODE_MISS) begin
         m = kind[0] | kind[1];
      end else if (sel == `SUB_DECODE_STARVE) begin
         m = kind[1];
      end else if (sel == `SUB_L1I_MISS) begin
         m = kind[2];
      end else if (sel == `SUB_L2_MISS) begin
         m = kind[3];
      end else if (sel == `SUB_ITLB_MISS) begin
         m = kind[4];
      end else if (sel == `SUB_STLB_MISS) begin
         m = kind[5];
      end
      return m;
   endfunction

   // empty slots in one cycle; a stalled cycle offers none
   function automatic logic [2:0] empty_count(input logic [2:0] filled,
                                              input logic stall);
      logic [2:0] n;
      n = 3'h0;
      if (!stall && filled < `ALLOC_SLOTS) begin
         n = `ALLOC_SLOTS - filled;
      end
      return n;
   endfunction

   // one more gap cycle reaches the programmed run length
   function automatic logic run_reaches(input logic [11:0] len,
                                        input logic [11:0] need);
      logic [12:0] next_len;
      next_len = {1'b0, len} + 13'h0001;
      return next_len >= {1'b0, need};
   endfunction

   // ----------------------------------------------------------------------
   // qualifier registers
   // ----------------------------------------------------------------------
   logic [63:0] fe_qual;
   logic [63:0] ocr_filt;

   // writes keep only defined fields; reserved bits are dropped at the
   // write so that neither the read-back nor the matching logic below
   // can ever see them, whatever software puts there
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         fe_qual <= `FEQ_RESET;
      end else if (WR_I.wr_fe) begin
         fe_qual <= WR_I.data & `FEQ_WMASK;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ocr_filt <= `OCR_RESET;
      end else if (WR_I.wr_ocr) begin
         ocr_filt <= WR_I.data & `OCR_WMASK;
      end
   end

   // read-back of the front-end qualifier, one cycle behind
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         FE_QUAL_O <= `FEQ_RESET;
      end else begin
         FE_QUAL_O <= fe_qual;
      end
   end

   // read-back of the off-core filter, one cycle behind
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         OCR_FILT_O <= `OCR_RESET;
      end else begin
         OCR_FILT_O <= ocr_filt;
      end
   end

   logic [7:0] sel;
   logic [11:0] run_need;
   logic [2:0] slot_need;
   assign sel = fe_qual[`FEQ_SEL_MSB:`FEQ_SEL_LSB];
   assign run_need = fe_qual[`FEQ_RUN_MSB:`FEQ_RUN_LSB];
   assign slot_need = fe_qual[`FEQ_SLOT_MSB:`FEQ_SLOT_LSB];

   // ----------------------------------------------------------------------
   // queue read-gap detection
   // ----------------------------------------------------------------------
   logic [2:0] empty_slots;
   logic gap_cycle;
   logic [11:0] run_len;
   logic run_done;
   evfilt_pkg::gap_state_e gap_state;
   // a run is a string of unstalled cycles that each leave enough slots
   // empty; stalled cycles are transparent. the run scores once when it
   // reaches the programmed length, also on its very first cycle when
   // the length is one or zero, and then waits in the hit state until
   // the run breaks. a new front-end setting restarts everything.

   // empty slots only count when the back end is not stalled
   assign empty_slots = empty_count(FILLED_SLOTS_I, BACK_STALL_I);
   assign gap_cycle = !BACK_STALL_I && empty_slots >= slot_need;
   // this cycle completes a run that has not scored yet
   assign run_done = gap_cycle && run_reaches(run_len, run_need) &&
                     (gap_state == evfilt_pkg::GAP_IDLE ||
                      gap_state == evfilt_pkg::GAP_RUN);

   // run tracking; a run scores at most once
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         run_len <= 12'h000;
         gap_state <= evfilt_pkg::GAP_IDLE;
      end else if (WR_I.wr_fe) begin
         run_len <= 12'h000;
         gap_state <= evfilt_pkg::GAP_IDLE;
      end else if (BACK_STALL_I) begin
         run_len <= run_len; // stalled cycles neither extend nor break
      end else if (!gap_cycle) begin
         run_len <= 12'h000;
         gap_state <= evfilt_pkg::GAP_IDLE;
      end else begin
         unique case (gap_state)
            evfilt_pkg::GAP_IDLE,
            evfilt_pkg::GAP_RUN: begin
               if (run_reaches(run_len, run_need)) begin
                  gap_state <= evfilt_pkg::GAP_HIT;
               end else begin
                  gap_state <= evfilt_pkg::GAP_RUN;
               end
               run_len <= run_len + 12'h001;
            end
            evfilt_pkg::GAP_HIT: begin
               run_len <= run_len;
            end
            default: begin
               gap_state <= evfilt_pkg::GAP_IDLE;
            end
         endcase
      end
   end

   // a qualifying gap waits for the next retiring instruction
   logic gap_pending;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         gap_pending <= 1'b0;
      end else if (WR_I.wr_fe) begin
         gap_pending <= 1'b0; // stale gap never scores under new setting
      end else if (run_done) begin
         gap_pending <= 1'b1; // new gap wins over the retire
      end else if (RETIRE_I.valid && RETIRE_I.arch_path) begin
         gap_pending <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // front-end retired event
   // ----------------------------------------------------------------------
   logic [57:0] last_line;
   logic last_line_ok;
   logic miss_hit;
   logic fe_fire;

   // a miss counts on the retirement that carries it, once per cache
   // line: repeats on the line just counted are dropped until another
   // line counts or the qualifier is rewritten. the line memory holds a
   // single line, so alternating lines each count again.
   // miss kinds already carry first-miss only; outside-boundary misses
   // are folded into the next retirement by the source
   assign miss_hit = sub_match(sel, RETIRE_I.miss_kind);
   always_comb begin
      fe_fire = 1'b0;
      if (RETIRE_I.valid && RETIRE_I.arch_path) begin
         if (sel == `SUB_QUEUE_GAP) begin
            fe_fire = gap_pending;
         end else if (miss_hit) begin
            // one count per line, pairs and straddlers counted once
            fe_fire = !(last_line_ok && last_line == RETIRE_I.line);
         end
      end
   end

   // remember the last counted line
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         last_line <= 58'h0;
         last_line_ok <= 1'b0;
      end else if (WR_I.wr_fe) begin
         last_line_ok <= 1'b0;
      end else if (fe_fire && sel != `SUB_QUEUE_GAP) begin
         last_line <= RETIRE_I.line;
         last_line_ok <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         FE_EVENT_O <= 1'b0;
      end else begin
         FE_EVENT_O <= fe_fire;
      end
   end

   // ----------------------------------------------------------------------
   // off-core response matching
   // ----------------------------------------------------------------------
   // a response counts when it meets all three fields: one of its
   // request kinds is enabled, its supplier is enabled or the catch-all
   // is set, and its snoop outcome is enabled. a field left all zero
   // therefore matches nothing.
   logic req_ok;
   logic sup_ok;
   logic snp_ok;
   logic req_load;
   logic req_own;
   logic req_fetch;
   logic req_misc;
   logic sup_any;
   logic sup_none;
   logic sup_l3;
   logic sup_l4;
   logic sup_mem;
   logic snp_plain;
   logic snp_probe;
   logic snp_fwd;
   logic snp_far;
   logic [13:0] sup_sel;
   logic [6:0] snp_sel;

   // request type, one term per defined bit; bits 14:3 never get here
   assign req_load = ocr_filt[`OCR_DEMAND_LOAD] & OCR_RSP_I.req[0];
   assign req_own = ocr_filt[`OCR_DEMAND_OWN] & OCR_RSP_I.req[1];
   assign req_fetch = ocr_filt[`OCR_DEMAND_FETCH] & OCR_RSP_I.req[2];
   assign req_misc = ocr_filt[`OCR_OTHER] & OCR_RSP_I.req_other;
   assign req_ok = req_load | req_own | req_fetch | req_misc;

   // supplier field 29:16 lines up with the response's supplier bits;
   // the response carries no super-line flag, so bit 30 is read-back only
   assign sup_sel = ocr_filt[`OCR_SUP_MSB:`OCR_ANY];
   assign sup_any = sup_sel[0];
   assign sup_none = sup_sel[1] & OCR_RSP_I.supplier[1];
   assign sup_l3 = |(sup_sel[4:2] & OCR_RSP_I.supplier[4:2]);
   assign sup_l4 = sup_sel[6] & OCR_RSP_I.supplier[6];
   assign sup_mem = sup_sel[10] & OCR_RSP_I.supplier[10];
   assign sup_ok = sup_any | sup_none | sup_l3 | sup_l4 | sup_mem;

   // snoop bits 31..37 matched one to one
   assign snp_sel = ocr_filt[`OCR_SNOOP_MSB:`OCR_SNOOP_LSB];
   assign snp_plain = |(snp_sel[1:0] & OCR_RSP_I.snoop[1:0]);
   assign snp_probe = |(snp_sel[3:2] & OCR_RSP_I.snoop[3:2]);
   assign snp_fwd = |(snp_sel[5:4] & OCR_RSP_I.snoop[5:4]);
   assign snp_far = snp_sel[6] & OCR_RSP_I.snoop[6];
   assign snp_ok = snp_plain | snp_probe | snp_fwd | snp_far;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         OCR_MATCH_O <= 1'b0;
      end else begin
         OCR_MATCH_O <= OCR_RSP_I.valid && req_ok && sup_ok && snp_ok;
      end
   end

endmodule
`default_nettype wire

/* File: evfilt_asserts.sv */
// evfilt_asserts.sv: port checks of the event qualifier block.
// assumes: bound to evfilt; evfilt_consts.svh on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "evfilt_consts.svh"
module evfilt_asserts (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire evfilt_pkg::reg_wr_s WR_I,
   input wire evfilt_pkg::retire_s RETIRE_I,
   input wire evfilt_pkg::ocr_rsp_s OCR_RSP_I,
   input wire logic [63:0] FE_QUAL_O,
   input wire logic [63:0] OCR_FILT_O,
   input wire logic FE_EVENT_O,
   input wire logic OCR_MATCH_O
);
   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // readbacks show the masked write two edges later
   fe_write_a: assert property (WR_I.wr_fe |-> ##2
      FE_QUAL_O == ($past(WR_I.data, 2) & `FEQ_WMASK)) else $error("fe readback");
   ocr_write_a: assert property (WR_I.wr_ocr |-> ##2
      OCR_FILT_O == ($past(WR_I.data, 2) & `OCR_WMASK)) else $error("ocr readback");
   fe_hold_a: assert property (!WR_I.wr_fe |-> ##2 $stable(FE_QUAL_O))
      else $error("fe readback moved");
   ocr_hold_a: assert property (!WR_I.wr_ocr |-> ##2 $stable(OCR_FILT_O))
      else $error("ocr readback moved");
   // events need a real cause one cycle before
   arch_only_a: assert property (FE_EVENT_O |->
      $past(RETIRE_I.valid && RETIRE_I.arch_path)) else $error("fe cause");
   ocr_cause_a: assert property (OCR_MATCH_O |->
      $past(OCR_RSP_I.valid && (|OCR_RSP_I.req || OCR_RSP_I.req_other)))
      else $error("ocr cause");
   line_once_a: assert property (FE_EVENT_O && $past(FE_EVENT_O) &&
      !$past(WR_I.wr_fe) && !$past(WR_I.wr_fe, 2) &&
      FE_QUAL_O[7:0] != `SUB_QUEUE_GAP |->
      $past(RETIRE_I.line) != $past(RETIRE_I.line, 2)) else $error("same line");
   any_bit_a: assert property ($rose(OCR_FILT_O[16]) |->
      $past(WR_I.wr_ocr, 2) && $past(WR_I.data[16], 2)) else $error("any bit");
   // main scenarios
   fe_seen_c: cover property (FE_EVENT_O);
   ocr_seen_c: cover property (OCR_MATCH_O);
   fe_pair_c: cover property (FE_EVENT_O && $past(FE_EVENT_O));
endmodule
bind evfilt evfilt_asserts evfilt_asserts_i (.CLK_I(CLK_I), .RST_I(RST_I),
   .WR_I(WR_I), .RETIRE_I(RETIRE_I), .OCR_RSP_I(OCR_RSP_I),
   .FE_QUAL_O(FE_QUAL_O), .OCR_FILT_O(OCR_FILT_O),
   .FE_EVENT_O(FE_EVENT_O), .OCR_MATCH_O(OCR_MATCH_O));
`default_nettype wire

/* File: evfilt_consts.svh */
// evfilt_consts.svh: bit positions, reset values and masks of the two
// event qualifier registers.
// assumes: included by the package and the filter module by bare name.
`ifndef EVFILT_CONSTS_SVH
`define EVFILT_CONSTS_SVH

// ----------------------------------------------------------------------
// front-end qualifier layout
// ----------------------------------------------------------------------
`define FEQ_SEL_LSB 0
`define FEQ_SEL_MSB 7
`define FEQ_RUN_LSB 8
`define FEQ_RUN_MSB 19
`define FEQ_SLOT_LSB 20
`define FEQ_SLOT_MSB 22
`define FEQ_WMASK 64'h0000_0000_007f_ffff
`define FEQ_RESET 64'h0000_0000_0000_0000

// ----------------------------------------------------------------------
// front-end sub-event codes
// ----------------------------------------------------------------------
`define SUB_ANY_DECODE_MISS 8'h01
`define SUB_DECODE_STARVE 8'h11
`define SUB_L1I_MISS 8'h12
`define SUB_L2_MISS 8'h13
`define SUB_ITLB_MISS 8'h14
`define SUB_STLB_MISS 8'h15
`define SUB_QUEUE_GAP 8'h06
`define ALLOC_SLOTS 3'h4

// ----------------------------------------------------------------------
// off-core response filter layout
// ----------------------------------------------------------------------
`define OCR_DEMAND_LOAD 0
`define OCR_DEMAND_OWN 1
`define OCR_DEMAND_FETCH 2
`define OCR_OTHER 15
`define OCR_ANY 16
`define OCR_NO_SUPPLIER 17
`define OCR_L3_MOD 18
`define OCR_L3_EXC 19
`define OCR_L3_SHR 20
`define OCR_FOURTH_LEVEL_HIT 22
`define OCR_LOCAL_MEM 26
`define OCR_SUPER_LINE 30
`define OCR_SUP_MSB 29
`define OCR_SNOOP_LSB 31
`define OCR_SNOOP_MSB 37
`define OCR_WMASK 64'h0000_003f_c45f_8007
`define OCR_RESET 64'h0000_0000_0000_0000

`endif

/* File: evfilt_pkg.sv */
// evfilt_pkg.sv: types shared by the event qualification logic.
// assumes: evfilt_consts.svh is on the include path.
`include "evfilt_consts.svh"

package evfilt_pkg;

   // register write port
   typedef struct packed {
      logic wr_fe;
      logic wr_ocr;
      logic [63:0] data;
   } reg_wr_s;

   // one retiring instruction with its front-end miss history
   typedef struct packed {
      logic valid;
      logic arch_path;
      logic fused_pair;
      logic [57:0] line;
      logic [7:0] miss_kind;
   } retire_s;

   // one off-core response
   typedef struct packed {
      logic valid;
      logic [2:0] req;
      logic req_other;
      logic [13:0] supplier;
      logic [6:0] snoop;
   } ocr_rsp_s;

   typedef enum logic [1:0] {
      GAP_IDLE = 2'b00,
      GAP_RUN = 2'b01,
      GAP_HIT = 2'b10
   } gap_state_e;

endpackage

/* File: evfilt_test.sv */
// evfilt_test.sv: self-checking bench with a reference model.
// assumes: evfilt_pkg and evfilt_consts.svh compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "evfilt_consts.svh"
module evfilt_test;
   // -----------------------------------------------------------------
   // stimulus, model and checks
   // -----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] fill = 3'h4, next_fill = 3'h4;
   logic stall = 1'b0, next_stall = 1'b0;
   evfilt_pkg::reg_wr_s wr = '0, next_wr = '0;
   evfilt_pkg::retire_s ret = '0, next_ret = '0;
   evfilt_pkg::ocr_rsp_s rsp = '0, next_rsp = '0;
   logic [63:0] fe_q, ocr_q, m_fe, m_ocr, r_fe, r_ocr, filt;
   logic fe_ev, ocr_m, e_fe, e_ocr, pend, has_last;
   logic [57:0] last;
   logic [15:0] seed = 16'h12c4;
   logic [7:0] codes [6] = '{8'h01, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
   int n_errors = 0, n_compared = 0, run, kk, need;
   evfilt evfilt_i (.CLK_I(clk), .RST_I(rst), .WR_I(wr),
      .FILLED_SLOTS_I(fill), .BACK_STALL_I(stall), .RETIRE_I(ret),
      .OCR_RSP_I(rsp), .FE_QUAL_O(fe_q), .OCR_FILT_O(ocr_q),
      .FE_EVENT_O(fe_ev), .OCR_MATCH_O(ocr_m));
   // 50 MHz clock
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // each of n edges: staged inputs go out, pulses clear
   task tick(input int n);
      repeat (n) begin
         @(posedge clk);
         wr <= next_wr;
         ret <= next_ret;
         rsp <= next_rsp;
         fill <= next_fill;
         stall <= next_stall;
         next_wr = '0;
         next_ret = '0;
         next_rsp = '0;
      end
   endtask
   task write(input logic fe, input logic [63:0] d);
      next_wr = '{fe, ~fe, d};
      tick(1);
   endtask
   task retire(input logic arch, input logic [57:0] ln, input logic [7:0] k);
      next_ret = '{1'b1, arch, ln[0], ln, k};
      tick(1);
   endtask
   task check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // reference model on the design's edges
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         {m_fe, m_ocr, r_fe, r_ocr} = '0;
         {e_fe, e_ocr, pend, has_last, last} = '0;
         run = 0;
      end else begin
         r_fe = m_fe;
         r_ocr = m_ocr;
         e_fe = 1'b0;
         kk = -1;
         for (int j = 0; j < 6; j++) if (codes[j] == m_fe[7:0]) kk = j;
         need = (m_fe[19:8] == 12'h0) ? 1 : int'(m_fe[19:8]);
         if (m_fe[7:0] == `SUB_QUEUE_GAP) begin
            e_fe = ret.valid && ret.arch_path && pend;
            if (e_fe) pend = 1'b0;
            if (!stall && 4 - int'(fill) >= int'(m_fe[22:20])) run++;
            else if (!stall) run = 0;
            if (!stall && run == need) pend = 1'b1;
         end else if (kk >= 0 && ret.valid && ret.arch_path &&
               (ret.miss_kind[kk] || (kk == 0 && ret.miss_kind[1])) &&
               !(has_last && ret.line == last)) begin
            e_fe = 1'b1;
            has_last = 1'b1;
            last = ret.line;
         end
         e_ocr = rsp.valid && ((rsp.req & m_ocr[2:0]) != 0 ||
            (rsp.req_other && m_ocr[15])) && (m_ocr[16] ||
            (rsp.supplier & m_ocr[29:16]) != 0) &&
            (rsp.snoop & m_ocr[37:31]) != 0;
         if (wr.wr_fe) {pend, has_last, run} = '0;
         if (wr.wr_fe) m_fe = wr.data & `FEQ_WMASK;
         if (wr.wr_ocr) m_ocr = wr.data & `OCR_WMASK;
      end
   end
   // every settled result against the model
   always @(negedge clk) begin
      if (!rst) begin
         check(fe_ev, e_fe);
         check(ocr_m, e_ocr);
         check(fe_q, r_fe);
         check(ocr_q, r_ocr);
      end
   end
   // main sequence; the bench plays software with event c6h/01h set
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      write(1'b1, '1);
      write(1'b0, '1);
      tick(2);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         write(1'b1, {56'h0, codes[i]});
         retire(1'b1, 58'h10 + 58'(i), 8'h01 << i);
         retire(1'b1, 58'h10 + 58'(i), 8'h3f);
         retire(1'b0, 58'h20, 8'h3f);
         retire(1'b1, 58'h21, ~(8'h01 << i));
         repeat (8) begin
            seed = lfsr(seed);
            retire(seed[0], {55'h0, seed[3:1]}, seed[15:8]);
         end
      end
      $display("test sub-events done");
      write(1'b1, 64'h0000_0000_0020_0206);
      next_fill = 3'h2;
      tick(1);
      next_stall = 1'b1;
      tick(1);
      next_stall = 1'b0;
      tick(1);
      next_fill = 3'h4;
      retire(1'b1, 58'h30, 8'h00);
      next_fill = 3'h2;
      tick(1);
      next_fill = 3'h3;
      tick(1);
      next_fill = 3'h4;
      retire(1'b1, 58'h31, 8'h00);
      $display("test gap done");
      for (int i = 0; i < 96; i++) begin
         seed = lfsr(seed);
         filt = {lfsr(seed), seed, lfsr(~seed), seed} | 64'h8000_0000;
         if (i % 8 == 0) write(1'b0, filt);
         next_rsp = '{seed[12] | seed[13], seed[2:0], seed[3],
            seed[15:2] & lfsr(seed), seed[10:4]};
         tick(1);
      end
      $display("test offcore done");
      @(posedge clk);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(3);
      $display("test reset done");
      close_out;
   end
endmodule
`default_nettype wire
